// [hw/omc_pkg.sv]
// Package for the operating mode controller: register map, fields, states
package omc_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int PIN_W = 8;

	// Register offsets
	localparam logic [3:0] SOPT_OFF = 4'h0;  // system_options_reg
	localparam logic [3:0] PMC1_OFF = 4'h1;  // power_mgmt_control_one
	localparam logic [3:0] PMC2_OFF = 4'h2;  // power_mgmt_control_two
	localparam logic [3:0] DBGSC_OFF = 4'h3; // debug_status_control_reg
	localparam logic [3:0] MODE_OFF = 4'h4;  // mode status, read only
	localparam logic [3:0] PORT_OFF = 4'h5;  // port data register
	localparam logic [3:0] PDIR_OFF = 4'h6;  // port direction register

	// Field positions
	localparam int STOP_ENABLE_BIT = 7;
	localparam int LOW_VOLTAGE_DETECT_ENABLE_BIT = 2;
	localparam int LOW_VOLTAGE_STOP_ENABLE_BIT = 3;
	localparam int PPDC_BIT = 0;
	localparam int PARTIAL_POWERDOWN_ACK_BIT = 2;
	localparam int PARTIAL_POWERDOWN_FLAG_BIT = 3;
	localparam int DEBUG_STOP_ENABLE_BIT = 7;

	// Reset values
	localparam logic [7:0] SOPT_RST = 8'h80;
	localparam logic [7:0] PMC1_RST = 8'h0c;
	localparam logic [7:0] PMC2_RST = 8'h00;
	localparam logic [7:0] DBGSC_RST = 8'h00;
	localparam logic [7:0] PORT_RST = 8'h00;

	// Debug status answers
	localparam logic [1:0] DST_OK = 2'h0;
	localparam logic [1:0] DST_LOWPWR = 2'h1;
	localparam logic [1:0] DST_REFUSED = 2'h2;

	// Operating modes, Gray along run-wait-stop3-stop2
	typedef enum logic [2:0] {
		MODE_RUN = 3'b000,
		MODE_WAIT = 3'b001,
		MODE_STOP3 = 3'b011,
		MODE_STOP2 = 3'b010,
		MODE_BACKGROUND_INSTRUCTION = 3'b110
	} omc_mode_type;

	// Serial debug command classes
	typedef enum logic [2:0] {
		DCMD_MEM = 3'h0,
		DCMD_MEM_STAT = 3'h1,
		DCMD_DREG = 3'h2,
		DCMD_BACKGROUND = 3'h3,
		DCMD_CPUREG = 3'h4,
		DCMD_TRACE = 3'h5,
		DCMD_GO = 3'h6
	} omc_dcmd_type;

	typedef struct packed {
		logic valid;
		omc_dcmd_type cmd;
	} omc_dbg_req_type;

	typedef struct packed {
		logic done;
		logic [1:0] status;
		logic mem_access;
		logic cpu_access;
	} omc_dbg_rsp_type;

	typedef struct packed {
		logic wait_instr;
		logic stop_instr;
		logic background_instruction_instr;
		logic bdc_break;
		logic dbg_break;
		logic irq;
	} omc_cpu_ev_type;

	typedef struct packed {
		logic rtc;
		logic lvd;
		logic analog_comparator;
		logic adc;
		logic sci;
		logic pin;
	} omc_wake_type;

	typedef struct packed {
		logic cpu_clk_en;
		logic bus_clk_en;
		logic dbg_clk_en;
		logic reg_full;
		logic analog_stop_ok;
		logic power_down;
	} omc_pwr_type;

endpackage

// [hw/omc_ctrl.sv]
// Operating mode controller: run, background, wait and stop modes
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

// Function
// - Enter background mode if mode pin low at power-on or after forced reset.
// - BACKGROUND command, background instruction or breakpoints enter background mode.
// - In background mode the CPU is suspended, awaiting debug commands.
// - Memory, status, debug register and BACKGROUND commands work in run and background.
// - CPU register, trace and resume commands only in background mode.
// - WAIT stops CPU clock, clears interrupt mask; system clocks keep running.
// - Any interrupt in wait mode wakes the CPU into its service routine.
// - In wait or stop only BACKGROUND and status commands; status reports error.
// - BACKGROUND in wait mode goes straight to background mode.
// - BACKGROUND in stop wakes to background mode only with debug stop enable.
// - STOP with stop enable clear causes an illegal-opcode reset.
// - Stop and debug enabled: stop3, debug clocks on, regulator fully on.
// - Debug off but both low-voltage bits set: stop3, regulator active.
// - Every stop mode halts bus clock and CPU clock.
// - Stop3 keeps all register, RAM and pin state.
// - Stop3 ends on reset pin or on RTC, LVD, ANALOG_COMPARATOR, ADC, SCI, pin interrupts.
// - ADC and comparator run in stop only if low-voltage detect enabled on entry.
// - Entering stop2 latches pin controls and powers down all but RAM.
// - Stop2 ends only on wakeup reset pin or enabled real-time counter.
// - Stop2 wake acts as power-on reset, low-voltage reset enabled, vector fetched.
// - After stop2 wake the flag is set; flag and latches hold until ack.
// - On ack, pins take current port register values.
// - Opened latches give pins to port registers unless peripheral re-enabled.
module omc_ctrl
	import omc_pkg::*;
(
	input wire logic clock,                       // 25 MHz bus clock
	input wire logic srst,                        // Sync reset, active high
	input wire logic por,                         // Power-on reset event
	input wire logic force_background_instruction_rst,              // Debug-forced reset event
	input wire logic mode_sel_in,                 // debug_mode_select_pin level
	input wire logic wakeup_reset_pin_n,          // Wake/reset pin, low active
	input wire logic rtc_wake_en,                 // Real-time counter enabled
	input wire omc_cpu_ev_type cpu_ev,            // CPU events
	input wire omc_wake_type wake_ev,             // Stop3 wake sources
	input wire omc_dbg_req_type dbg_req,          // Serial debug command
	input wire logic [PIN_W-1:0] periph_en,       // Peripheral owns pin
	input wire logic [PIN_W-1:0] periph_out,      // Peripheral pin data
	input wire logic [ADDR_W-1:0] addr,           // Register address
	input wire logic [DATA_W-1:0] wdata,          // Write data
	input wire logic wr,                          // Write strobe
	input wire logic rd,                          // Read strobe
	output logic [DATA_W-1:0] rdata,              // Read data, cycle after rd
	output omc_mode_type mode,                    // Current mode
	output omc_pwr_type pwr,                      // Clock and power controls
	output omc_dbg_rsp_type dbg_rsp,              // Debug command answer
	output logic irq_mask_clr,                    // Clear interrupt mask bit
	output logic cpu_int_take,                    // Take interrupt vector
	output logic reset_req,                       // System reset request
	output logic illegal_op_rst,                  // Illegal opcode reset
	output logic lv_reset_en,                     // Low-voltage reset enable
	output logic [PIN_W-1:0] pin_out,             // Pin output data
	output logic [PIN_W-1:0] pin_oe_n             // Pin enable, low drives
);

	logic [7:0] sopt;
	logic [7:0] pmc1;
	logic ppdc;
	logic partial_powerdown_flag;
	logic debug_stop_enable;
	logic [7:0] port_data;
	logic [7:0] port_dir;
	logic pin_latched;
	logic lvd_on_entry;
	omc_mode_type next_mode;
	logic [PIN_W-1:0] next_pin_out;
	logic [PIN_W-1:0] next_pin_oe_n;
	logic stop2_wake;

	function automatic logic is_lowpwr(input omc_mode_type m);
		is_lowpwr = (m == MODE_WAIT) || (m == MODE_STOP3) ||
			(m == MODE_STOP2);
	endfunction

	function automatic logic is_stop(input omc_mode_type m);
		is_stop = (m == MODE_STOP3) || (m == MODE_STOP2);
	endfunction

	// Stop level picked by the control bits
	function automatic omc_mode_type stop_sel(input logic dbg,
		input logic low_voltage_detect_enable, input logic low_voltage_stop_enable, input logic pd);
		if (dbg)
			stop_sel = MODE_STOP3;
		else if (low_voltage_detect_enable && low_voltage_stop_enable)
			stop_sel = MODE_STOP3;
		else if (pd)
			stop_sel = MODE_STOP2;
		else
			stop_sel = MODE_STOP3;
	endfunction

	assign stop2_wake = (mode == MODE_STOP2) &&
		(!wakeup_reset_pin_n || (rtc_wake_en && wake_ev.rtc));

	// Mode sequencing
	always_comb begin
		next_mode = mode;
		case (mode)
			MODE_RUN: begin
				if ((dbg_req.valid && dbg_req.cmd == DCMD_BACKGROUND) ||
					cpu_ev.background_instruction_instr || cpu_ev.bdc_break ||
					cpu_ev.dbg_break)
					next_mode = MODE_BACKGROUND_INSTRUCTION;
				else if (cpu_ev.wait_instr)
					next_mode = MODE_WAIT;
				else if (cpu_ev.stop_instr && sopt[STOP_ENABLE_BIT])
					next_mode = stop_sel(debug_stop_enable, pmc1[LOW_VOLTAGE_DETECT_ENABLE_BIT],
						pmc1[LOW_VOLTAGE_STOP_ENABLE_BIT], ppdc);
			end
			MODE_WAIT: begin
				if (dbg_req.valid && dbg_req.cmd == DCMD_BACKGROUND)
					next_mode = MODE_BACKGROUND_INSTRUCTION;
				else if (cpu_ev.irq)
					next_mode = MODE_RUN;
			end
			MODE_STOP3: begin
				if (dbg_req.valid && dbg_req.cmd == DCMD_BACKGROUND &&
					debug_stop_enable)
					next_mode = MODE_BACKGROUND_INSTRUCTION;
				else if (!wakeup_reset_pin_n || (|wake_ev))
					next_mode = MODE_RUN;
			end
			MODE_STOP2: begin
				if (stop2_wake)
					next_mode = MODE_RUN;
			end
			MODE_BACKGROUND_INSTRUCTION: begin
				if (dbg_req.valid && dbg_req.cmd == DCMD_GO)
					next_mode = MODE_RUN;
			end
			default: next_mode = MODE_RUN;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst)
			mode <= MODE_RUN;
		else if (por || force_background_instruction_rst)
			mode <= mode_sel_in ? MODE_RUN : MODE_BACKGROUND_INSTRUCTION;
		else
			mode <= next_mode;
	end

	// Clock and power controls follow the next mode
	always_ff @(posedge clock) begin
		if (srst) begin
			pwr <= '{cpu_clk_en: 1'b1, bus_clk_en: 1'b1,
				dbg_clk_en: 1'b1, reg_full: 1'b1,
				analog_stop_ok: 1'b0, power_down: 1'b0};
		end else begin
			pwr.cpu_clk_en <= (next_mode == MODE_RUN);
			pwr.bus_clk_en <= !is_stop(next_mode);
			pwr.dbg_clk_en <= !is_stop(next_mode) || debug_stop_enable;
			pwr.reg_full <= !is_stop(next_mode) || debug_stop_enable ||
				(pmc1[LOW_VOLTAGE_DETECT_ENABLE_BIT] && pmc1[LOW_VOLTAGE_STOP_ENABLE_BIT]);
			pwr.analog_stop_ok <= (next_mode == MODE_STOP3) &&
				lvd_on_entry;
			pwr.power_down <= (next_mode == MODE_STOP2);
		end
	end

	// Low-voltage state captured on stop3 entry
	always_ff @(posedge clock) begin
		if (srst)
			lvd_on_entry <= 1'b0;
		else if (mode == MODE_RUN && next_mode == MODE_STOP3)
			lvd_on_entry <= pmc1[LOW_VOLTAGE_DETECT_ENABLE_BIT];
	end

	// CPU side events
	always_ff @(posedge clock) begin
		if (srst) begin
			irq_mask_clr <= 1'b0;
			cpu_int_take <= 1'b0;
			reset_req <= 1'b0;
			illegal_op_rst <= 1'b0;
		end else begin
			irq_mask_clr <= (mode == MODE_RUN) &&
				(next_mode == MODE_WAIT);
			cpu_int_take <= (next_mode == MODE_RUN) &&
				((mode == MODE_WAIT) ||
				(mode == MODE_STOP3 && wakeup_reset_pin_n));
			reset_req <= ((mode == MODE_STOP3) && !wakeup_reset_pin_n)
				|| stop2_wake;
			illegal_op_rst <= (mode == MODE_RUN) &&
				(next_mode == MODE_RUN) && cpu_ev.stop_instr &&
				!sopt[STOP_ENABLE_BIT];
		end
	end

	// Debug command filter
	always_ff @(posedge clock) begin
		if (srst) begin
			dbg_rsp <= '0;
		end else begin
			dbg_rsp <= '0;
			if (dbg_req.valid) begin
				dbg_rsp.done <= 1'b1;
				if (is_lowpwr(mode)) begin
					if (dbg_req.cmd == DCMD_MEM_STAT)
						dbg_rsp.status <= DST_LOWPWR;
					else if (dbg_req.cmd != DCMD_BACKGROUND ||
						(mode != MODE_WAIT && !debug_stop_enable))
						dbg_rsp.status <= DST_REFUSED;
				end else begin
					case (dbg_req.cmd)
						DCMD_MEM, DCMD_MEM_STAT:
							dbg_rsp.mem_access <= 1'b1;
						DCMD_DREG, DCMD_BACKGROUND:
							dbg_rsp.status <= DST_OK;
						DCMD_CPUREG, DCMD_TRACE, DCMD_GO: begin
							if (mode == MODE_BACKGROUND_INSTRUCTION)
								dbg_rsp.cpu_access <= 1'b1;
							else
								dbg_rsp.status <= DST_REFUSED;
						end
						default: dbg_rsp.status <= DST_REFUSED;
					endcase
				end
			end
		end
	end

	// Debug stop enable, written through the register port in any mode
	always_ff @(posedge clock) begin
		if (srst)
			debug_stop_enable <= DBGSC_RST[DEBUG_STOP_ENABLE_BIT];
		else if (wr && addr == DBGSC_OFF)
			debug_stop_enable <= wdata[DEBUG_STOP_ENABLE_BIT];
	end

	// Software registers; stop2 wake resets them like power-on
	always_ff @(posedge clock) begin
		if (srst || stop2_wake) begin
			sopt <= SOPT_RST;
			pmc1 <= PMC1_RST;
			ppdc <= PMC2_RST[PPDC_BIT];
			port_data <= PORT_RST;
			port_dir <= PORT_RST;
		end else if (wr) begin
			case (addr)
				SOPT_OFF: sopt <= wdata;
				PMC1_OFF: pmc1 <= wdata;
				PMC2_OFF: ppdc <= wdata[PPDC_BIT];
				PORT_OFF: port_data <= wdata;
				PDIR_OFF: port_dir <= wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst)
			lv_reset_en <= 1'b0;
		else if (stop2_wake)
			lv_reset_en <= 1'b1;
		else if (wr && addr == PMC1_OFF)
			lv_reset_en <= wdata[LOW_VOLTAGE_DETECT_ENABLE_BIT];
	end

	// Partial power-down flag and pin latch; set wins over ack
	always_ff @(posedge clock) begin
		if (srst) begin
			partial_powerdown_flag <= 1'b0;
			pin_latched <= 1'b0;
		end else if (stop2_wake) begin
			partial_powerdown_flag <= 1'b1;
			pin_latched <= 1'b1;
		end else if (mode == MODE_RUN && next_mode == MODE_STOP2) begin
			pin_latched <= 1'b1;
		end else if (wr && addr == PMC2_OFF && wdata[PARTIAL_POWERDOWN_ACK_BIT]) begin
			partial_powerdown_flag <= 1'b0;
			pin_latched <= 1'b0;
		end
	end

	// Pin drive: held while latched, else peripheral or port
	always_comb begin
		next_pin_out = pin_out;
		next_pin_oe_n = pin_oe_n;
		if (!pin_latched && !(mode == MODE_RUN && next_mode == MODE_STOP2))
			begin
			next_pin_out = (periph_en & periph_out) |
				(~periph_en & port_data);
			next_pin_oe_n = ~(periph_en | port_dir);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			pin_out <= '0;
			pin_oe_n <= '1;
		end else begin
			pin_out <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
		end
	end

	// Register read port
	always_ff @(posedge clock) begin
		if (srst) begin
			rdata <= '0;
		end else if (rd) begin
			case (addr)
				SOPT_OFF: rdata <= sopt;
				PMC1_OFF: rdata <= pmc1;
				PMC2_OFF: rdata <= {4'h0, partial_powerdown_flag, 2'h0, ppdc};
				DBGSC_OFF: rdata <= {debug_stop_enable, 7'h00};
				MODE_OFF: rdata <= {5'h00, mode};
				PORT_OFF: rdata <= port_data;
				PDIR_OFF: rdata <= port_dir;
				default: rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end

	stop_illegal_a: assert property (@(posedge clock) disable iff (srst)
		mode == MODE_RUN && cpu_ev.stop_instr && !sopt[STOP_ENABLE_BIT] &&
		!cpu_ev.background_instruction_instr && !cpu_ev.wait_instr && !dbg_req.valid &&
		!cpu_ev.bdc_break && !cpu_ev.dbg_break && !por && !force_background_instruction_rst
		|=> illegal_op_rst && mode == MODE_RUN)
		else $error("illegal stop not reset");
	stop_clocks_a: assert property (@(posedge clock) disable iff (srst)
		is_stop(mode) |-> !pwr.bus_clk_en && !pwr.cpu_clk_en)
		else $error("clocks run in stop");
	wait_wake_a: assert property (@(posedge clock) disable iff (srst)
		mode == MODE_WAIT && cpu_ev.irq && !dbg_req.valid && !por &&
		!force_background_instruction_rst |=> mode == MODE_RUN ##0 cpu_int_take)
		else $error("wait not woken");
	wait_mask_a: assert property (@(posedge clock) disable iff (srst)
		$rose(mode == MODE_WAIT) |-> irq_mask_clr ##0 pwr.bus_clk_en)
		else $error("wait entry wrong");
	background_instruction_cpu_a: assert property (@(posedge clock) disable iff (srst)
		mode == MODE_BACKGROUND_INSTRUCTION && $past(mode) == MODE_BACKGROUND_INSTRUCTION |-> !pwr.cpu_clk_en)
		else $error("cpu runs in background");
	lowpwr_stat_a: assert property (@(posedge clock) disable iff (srst)
		is_lowpwr(mode) && dbg_req.valid && dbg_req.cmd == DCMD_MEM_STAT
		|=> dbg_rsp.status == DST_LOWPWR && !dbg_rsp.mem_access)
		else $error("status cmd wrong");
	active_only_a: assert property (@(posedge clock) disable iff (srst)
		mode == MODE_RUN && dbg_req.valid && dbg_req.cmd == DCMD_TRACE
		|=> !dbg_rsp.cpu_access && dbg_rsp.status == DST_REFUSED)
		else $error("trace in run");
	partial_powerdown_flag_hold_a: assert property (@(posedge clock) disable iff (srst)
		partial_powerdown_flag && !(wr && addr == PMC2_OFF && wdata[PARTIAL_POWERDOWN_ACK_BIT])
		|=> partial_powerdown_flag && pin_latched)
		else $error("flag dropped early");
	stop2_wake_a: assert property (@(posedge clock) disable iff (srst)
		mode == MODE_STOP2 && !wakeup_reset_pin_n && !por &&
		!force_background_instruction_rst |=> reset_req && partial_powerdown_flag && mode == MODE_RUN)
		else $error("stop2 wake wrong");

	stop2_c: cover property (@(posedge clock) mode == MODE_STOP2 ##1
		mode == MODE_RUN ##[1:20] !partial_powerdown_flag);
	stop3_background_instruction_c: cover property (@(posedge clock)
		mode == MODE_STOP3 ##1 mode == MODE_BACKGROUND_INSTRUCTION);
	wait_c: cover property (@(posedge clock)
		mode == MODE_WAIT ##1 mode == MODE_RUN);

endmodule

// [bench/omc_dbg_host.sv]
// Background debug host model issuing serial debug commands
`timescale 1ns/1ps
module omc_dbg_host
	import omc_pkg::*;
(
	input wire logic clock, // Bus clock
	input wire omc_dbg_rsp_type dbg_rsp, // Answer from device
	output omc_dbg_req_type dbg_req // Command to device
);
	initial dbg_req = '0;

	// One command; answer caught in the cycle after it is taken
	task automatic send(input omc_dcmd_type c, output omc_dbg_rsp_type r);
		@(posedge clock);
		dbg_req <= '{valid: 1'b1, cmd: c};
		@(posedge clock);
		// Released line shows the inverse, not the last value
		dbg_req <= '{valid: 1'b0, cmd: omc_dcmd_type'(~c)};
		#1 r = dbg_rsp;
	endtask
endmodule

// [bench/omc_ctrl_tb.sv]
// Self-checking bench for the operating mode controller
`timescale 1ns/1ps
module omc_ctrl_tb
	import omc_pkg::*;
;
	logic clock = 1'b0, srst = 1'b1, por = 1'b0, fbr = 1'b0, msel = 1'b1;
	logic wpin_n = 1'b1, rtc_en = 1'b0, wr = 1'b0, rd = 1'b0, clr = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [3:0] seen = 4'h0;
	logic [7:0] wdata = 8'h0, pen = 8'h0, pout = 8'h0;
	logic [7:0] rdata, pin_out, pin_oe_n;
	omc_cpu_ev_type cpu_ev = '0;
	omc_wake_type wake_ev = '0;
	omc_dbg_req_type dbg_req;
	omc_dbg_rsp_type dbg_rsp;
	omc_mode_type mode;
	omc_pwr_type pwr;
	logic imc, cit, rrq, ilr, lvr;
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;

	always #20 clock = ~clock;
	// Sticky record of the one-cycle pulses
	always @(posedge clock) seen <= clr ? 4'h0 : seen | {imc, cit, rrq, ilr};

	omc_ctrl dut (.clock(clock), .srst(srst), .por(por),
		.force_background_instruction_rst(fbr), .mode_sel_in(msel),
		.wakeup_reset_pin_n(wpin_n), .rtc_wake_en(rtc_en), .cpu_ev(cpu_ev),
		.wake_ev(wake_ev), .dbg_req(dbg_req), .periph_en(pen),
		.periph_out(pout), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .mode(mode), .pwr(pwr), .dbg_rsp(dbg_rsp),
		.irq_mask_clr(imc), .cpu_int_take(cit), .reset_req(rrq),
		.illegal_op_rst(ilr), .lv_reset_en(lvr), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n));

	omc_dbg_host host (.clock(clock), .dbg_rsp(dbg_rsp), .dbg_req(dbg_req));

	task automatic report_and_stop();
		$display("mismatches %0d of %0d checks", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge clock) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wrr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask

	task automatic ev(input logic [5:0] m);
		@(posedge clock);
		cpu_ev <= m;
		@(posedge clock);
		cpu_ev <= '0;
	endtask

	task automatic clear();
		@(posedge clock);
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
	endtask

	task automatic to_mode(input omc_mode_type m);
		for (int i = 0; i < 4 && mode !== m; i++) @(posedge clock);
		#1 chk("mode", {5'h0, m}, {5'h0, mode});
	endtask

	task automatic wait_seen(input int b, input string n);
		for (int i = 0; i < 4 && seen[b] !== 1'b1; i++) @(posedge clock);
		#1 chk(n, 8'h1, {7'h0, seen[b]});
	endtask

	task automatic dcmd(input omc_dcmd_type c, input logic [1:0] st);
		omc_dbg_rsp_type r;
		host.send(c, r);
		chk("done", 8'h1, {7'h0, r.done});
		chk("status", {6'h0, st}, {6'h0, r.status});
	endtask

	// Bits: debug stop enable, low_voltage_detect_enable, low_voltage_stop_enable, partial power-down
	task automatic cfg(input logic [3:0] c);
		wrr(DBGSC_OFF, {c[3], 7'h0});
		wrr(PMC1_OFF, {4'h0, c[1], c[2], 2'h0});
		wrr(PMC2_OFF, {7'h0, c[0]});
	endtask

	task automatic rpulse(input logic f, input logic s);
		@(posedge clock);
		msel <= s;
		por <= !f;
		fbr <= f;
		@(posedge clock);
		por <= 1'b0;
		fbr <= 1'b0;
		msel <= 1'b1;
	endtask

	task automatic t_reset();
		logic [7:0] rv [8] = '{SOPT_RST, PMC1_RST, PMC2_RST, DBGSC_RST,
			8'h00, PORT_RST, 8'h00, 8'h00};
		for (int a = 0; a < 8; a++) rdc(a[3:0], rv[a]);
		chk("oe_n", 8'hff, pin_oe_n);
	endtask

	task automatic t_por();
		rpulse(1'b0, 1'b0);
		to_mode(MODE_BACKGROUND_INSTRUCTION);
		rpulse(1'b0, 1'b1);
		to_mode(MODE_RUN);
		rpulse(1'b1, 1'b0);
		to_mode(MODE_BACKGROUND_INSTRUCTION);
		dcmd(DCMD_GO, DST_OK);
		to_mode(MODE_RUN);
	endtask

	task automatic t_cmds();
		for (int c = 0; c < 7; c++)
			if (c != 3) dcmd(omc_dcmd_type'(c), c < 3 ? DST_OK : DST_REFUSED);
		dcmd(DCMD_BACKGROUND, DST_OK);
		to_mode(MODE_BACKGROUND_INSTRUCTION);
		chk("cpu_clk", 8'h0, {7'h0, pwr.cpu_clk_en});
		for (int c = 0; c < 6; c++) dcmd(omc_dcmd_type'(c), DST_OK);
		dcmd(DCMD_GO, DST_OK);
		to_mode(MODE_RUN);
	endtask

	task automatic t_events();
		logic [5:0] m [3] = '{6'h08, 6'h04, 6'h02};
		for (int i = 0; i < 3; i++) begin
			ev(m[i]);
			to_mode(MODE_BACKGROUND_INSTRUCTION);
			dcmd(DCMD_GO, DST_OK);
			to_mode(MODE_RUN);
		end
	endtask

	task automatic t_wait();
		omc_dbg_rsp_type r;
		clear();
		ev(6'h20);
		to_mode(MODE_WAIT);
		wait_seen(3, "mask_clr");
		chk("clk", 8'h1, {6'h0, pwr.cpu_clk_en, pwr.bus_clk_en});
		dcmd(DCMD_MEM, DST_REFUSED);
		host.send(DCMD_MEM_STAT, r);
		chk("stat", 8'h14, {3'h0, r});
		clear();
		ev(6'h01);
		to_mode(MODE_RUN);
		wait_seen(2, "int_take");
		ev(6'h20);
		to_mode(MODE_WAIT);
		dcmd(DCMD_BACKGROUND, DST_OK);
		to_mode(MODE_BACKGROUND_INSTRUCTION);
		dcmd(DCMD_GO, DST_OK);
		to_mode(MODE_RUN);
	endtask

	task automatic t_illegal();
		wrr(SOPT_OFF, 8'h00);
		clear();
		ev(6'h10);
		wait_seen(0, "illegal");
		to_mode(MODE_RUN);
		wrr(SOPT_OFF, SOPT_RST);
	endtask

	task automatic t_stop3();
		logic [3:0] cf [3] = '{4'b1001, 4'b0111, 4'b0100};
		for (int i = 0; i < 6; i++) begin
			cfg(cf[i % 3]);
			ev(6'h10);
			to_mode(MODE_STOP3);
			chk("clk", 8'h0, {6'h0, pwr.cpu_clk_en, pwr.bus_clk_en});
			chk("dbg_clk", {7'h0, cf[i % 3][3]}, {7'h0, pwr.dbg_clk_en});
			chk("reg", {7'h0, cf[i % 3] != 4'b0100}, {7'h0, pwr.reg_full});
			chk("analog", {7'h0, cf[i % 3][2]}, {7'h0, pwr.analog_stop_ok});
			if (i % 3 == 1) begin
				dcmd(DCMD_BACKGROUND, DST_REFUSED);
				dcmd(DCMD_MEM_STAT, DST_LOWPWR);
			end
			clear();
			@(posedge clock);
			wake_ev <= omc_wake_type'(6'h20 >> i);
			to_mode(MODE_RUN);
			wait_seen(2, "int_take");
			@(posedge clock);
			wake_ev <= '0;
		end
		cfg(4'b0100);
		ev(6'h10);
		to_mode(MODE_STOP3);
		clear();
		@(posedge clock);
		wpin_n <= 1'b0;
		@(posedge clock);
		wpin_n <= 1'b1;
		wait_seen(1, "reset_req");
		to_mode(MODE_RUN);
		cfg(4'b1000);
		ev(6'h10);
		to_mode(MODE_STOP3);
		dcmd(DCMD_BACKGROUND, DST_OK);
		to_mode(MODE_BACKGROUND_INSTRUCTION);
		dcmd(DCMD_GO, DST_OK);
		to_mode(MODE_RUN);
	endtask

	task automatic t_stop2();
		wrr(PORT_OFF, 8'h25);
		wrr(PDIR_OFF, 8'hff);
		cfg(4'b0011);
		chk("pins", 8'h25, pin_out);
		ev(6'h10);
		to_mode(MODE_STOP2);
		chk("pdown", 8'h1, {7'h0, pwr.power_down});
		@(posedge clock);
		wake_ev <= 6'h20;
		repeat (3) @(posedge clock);
		wake_ev <= '0;
		to_mode(MODE_STOP2);
		clear();
		@(posedge clock);
		wpin_n <= 1'b0;
		@(posedge clock);
		wpin_n <= 1'b1;
		wait_seen(1, "reset_req");
		to_mode(MODE_RUN);
		chk("lv_reset", 8'h1, {7'h0, lvr});
		rdc(SOPT_OFF, SOPT_RST);
		rdc(PMC2_OFF, 8'h08);
		@(posedge clock);
		pen <= 8'h80;
		pout <= 8'h80;
		wrr(PORT_OFF, 8'h1a);
		wrr(PDIR_OFF, 8'hff);
		chk("pins", 8'h25, pin_out);
		wrr(PMC2_OFF, 8'h04);
		rdc(PMC2_OFF, 8'h00);
		chk("pins", 8'h9a, pin_out);
		chk("oe_n", 8'h00, pin_oe_n & 8'h7f);
	endtask

	initial begin
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		t_reset();
		t_por();
		t_cmds();
		t_events();
		t_wait();
		t_illegal();
		t_stop3();
		t_stop2();
		report_and_stop();
	end
endmodule
